// *** pkg/lbs_pkg.sv ***
// Shared constants and types for the LED behavior sequencer
package lbs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_BEHAVIOR = 8'h81;
  localparam logic [7:0] ADDR_P1_PERIOD = 8'h84;
  localparam logic [7:0] BEHAVIOR_RST = 8'h00;
  localparam logic [7:0] P1_PERIOD_RST = 8'h20;
  localparam logic [7:0] BEHAVIOR_MASK = 8'h3F;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam int LED_NUM = 3;
  localparam int FIELD_W = 2;
  localparam int P1_EDGE_BIT = 7;
  localparam int PERIOD_W = 7;
  localparam int COUNT_W = 3;
  localparam int CNT_W = COUNT_W + 1;
  // ==========================================================
  // Duty and level scale
  localparam logic [7:0] DUTY_MIN_DEF = 8'h00;
  localparam logic [7:0] DUTY_MAX_DEF = 8'hFF;
  localparam logic [7:0] LEVEL_MIN = 8'h00;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;
  localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 7'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE = 7'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // ==========================================================
  // Timing: one period unit spans 2 * LEVEL_NUM fine ticks
  localparam int UNIT_MS = 32;
  localparam int CLK_PERIOD_NS = 5;
  localparam int LEVEL_NUM = 256;
  localparam int FINE_TICK_NS = UNIT_MS * 1000000 / 2 / LEVEL_NUM;
  localparam int FINE_TICK_CYC =
    (FINE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_PULSE1 = 2'h1,
    MODE_PULSE2 = 2'h2,
    MODE_BREATHE = 2'h3
  } lbs_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_FINISH = 2'h3
  } lbs_state_t;
endpackage

// *** pkg/lbs_chan_if.sv ***
// Carrier between the sequencer top and one channel engine
`timescale 1ns/100ps
interface lbs_chan_if;
  import lbs_pkg::*;
  lbs_mode_t mode;
  logic trig;
  logic start_on_release;
  logic [PERIOD_W-1:0] p1_period;
  logic [PERIOD_W-1:0] p2_period;
  logic [PERIOD_W-1:0] br_period;
  logic [COUNT_W-1:0] p1_count;
  logic [COUNT_W-1:0] p2_count;
  logic [7:0] duty_min;
  logic [7:0] duty_max;
  logic fine_tick;
  logic [7:0] level;
  logic [7:0] run_min;
  logic [7:0] run_max;
  logic actuated;
  modport ctrl (
    output mode, trig, start_on_release, p1_period, p2_period,
    output br_period, p1_count, p2_count, duty_min, duty_max,
    output fine_tick,
    input level, run_min, run_max, actuated
  );
  modport seq (
    input mode, trig, start_on_release, p1_period, p2_period,
    input br_period, p1_count, p2_count, duty_min, duty_max,
    input fine_tick,
    output level, run_min, run_max, actuated
  );
endinterface

// *** logic/lbs_chan.sv ***
// Per-channel behavior engine: trigger edges, state, ramp level
`timescale 1ns/100ps
module lbs_chan
  import lbs_pkg::*;
(
  input wire logic i_clk,    // System clock
  input wire logic i_arst_n, // Async reset, active low
  lbs_chan_if.seq bus        // Settings in, level out
);
  // ==========================================================
  // Helpers
  // A zero period behaves as one unit
  function automatic logic [PERIOD_W-1:0] per_eff(
    input logic [PERIOD_W-1:0] p);
    per_eff = (p == PERIOD_ZERO) ? PERIOD_ONE : p;
  endfunction

  lbs_state_t state_reg;
  logic trig_q_reg;
  logic [PERIOD_W-1:0] per_reg;
  logic [PERIOD_W-1:0] step_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] level_reg;
  logic [7:0] min_reg;
  logic [7:0] max_reg;
  logic up_reg;
  logic rise;
  logic fall;
  logic p1_go;
  logic go;
  logic step_wrap;
  logic cycle_end;
  logic [PERIOD_W-1:0] per_sel;
  logic [CNT_W-1:0] cnt_sel;

  // ==========================================================
  // Trigger edges; a source switch shows up as an ordinary edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_q_reg <= 1'b0;
    end else begin
      trig_q_reg <= bus.trig;
    end
  end
  assign rise = bus.trig & ~trig_q_reg;
  assign fall = ~bus.trig & trig_q_reg;
  assign p1_go = bus.start_on_release ? fall : rise;
  assign go = (bus.mode == MODE_PULSE1) ? p1_go : rise;
  assign step_wrap = bus.fine_tick && (step_reg >= per_reg - PERIOD_ONE);
  assign cycle_end = step_wrap && !up_reg && (level_reg == LEVEL_MIN) &&
    (state_reg != ST_IDLE) && (bus.mode != MODE_DIRECT);

  // Parameters picked up at start, the Pulse 2 count again at release; other edits, bar the mode and Direct limits, wait for re-actuation
  always_comb begin
    per_sel = per_eff(bus.p1_period);
    cnt_sel = {1'b0, bus.p1_count} + CNT_ONE;
    unique case (bus.mode)
      MODE_PULSE2: begin
        per_sel = per_eff(bus.p2_period);
        cnt_sel = {1'b0, bus.p2_count} + CNT_ONE;
      end
      MODE_BREATHE: begin
        per_sel = per_eff(bus.br_period);
      end
      MODE_DIRECT, MODE_PULSE1: begin
        per_sel = per_eff(bus.p1_period);
      end
    endcase
  end

  // ==========================================================
  // Sequencer state; mode is read live so a change acts at once
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ONE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_RUN;
            cnt_reg <= cnt_sel;
          end
        end
        ST_RUN: begin
          unique case (bus.mode)
            MODE_DIRECT, MODE_BREATHE: begin
              if (fall) begin
                state_reg <= ST_IDLE;
              end
            end
            MODE_PULSE2: begin
              if (fall) begin
                state_reg <= ST_FINISH;
                // The pulse in progress ends first, then p2_count + 1 further ones
                cnt_reg <= {1'b0, bus.p2_count} + CNT_ONE + CNT_ONE;
              end
            end
            MODE_PULSE1: begin
              // Edges are not looked at until the count runs out
              if (cycle_end) begin
                cnt_reg <= cnt_reg - CNT_ONE;
                if (cnt_reg <= CNT_ONE) begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          endcase
        end
        ST_FINISH: begin
          if (rise && bus.mode == MODE_PULSE2) begin
            state_reg <= ST_RUN;
          end else if (cycle_end) begin
            cnt_reg <= cnt_reg - CNT_ONE;
            if (cnt_reg <= CNT_ONE) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Latched period and limits; Direct follows its limits live
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_reg <= PERIOD_ONE;
      min_reg <= DUTY_MIN_DEF;
      max_reg <= DUTY_MAX_DEF;
    end else if (bus.mode == MODE_DIRECT) begin
      min_reg <= bus.duty_min;
      max_reg <= bus.duty_max;
    end else if (state_reg == ST_IDLE && go) begin
      per_reg <= per_sel;
      min_reg <= bus.duty_min;
      max_reg <= bus.duty_max;
    end
  end

  // ==========================================================
  // Triangle ramp: 256 steps up and down, per_reg fine ticks each
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_reg <= LEVEL_MIN;
      up_reg <= 1'b1;
      step_reg <= PERIOD_ZERO;
    end else if (state_reg == ST_IDLE) begin
      level_reg <= LEVEL_MIN;
      up_reg <= 1'b1;
      step_reg <= PERIOD_ZERO;
    end else if (bus.mode == MODE_DIRECT) begin
      level_reg <= LEVEL_MAX;
    end else if (bus.fine_tick) begin
      step_reg <= step_wrap ? PERIOD_ZERO : step_reg + PERIOD_ONE;
      if (step_wrap) begin
        if (up_reg) begin
          if (level_reg == LEVEL_MAX) begin
            up_reg <= 1'b0;
          end else begin
            level_reg <= level_reg + 8'h01;
          end
        end else if (level_reg == LEVEL_MIN) begin
          up_reg <= 1'b1;
        end else begin
          level_reg <= level_reg - 8'h01;
        end
      end
    end
  end

  assign bus.level = level_reg;
  assign bus.run_min = min_reg;
  assign bus.run_max = max_reg;
  assign bus.actuated = (state_reg != ST_IDLE);

  // ==========================================================
  // Checks
  a_p1_ignore_edges: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_RUN && bus.mode == MODE_PULSE1 && !cycle_end)
    |=> state_reg == ST_RUN)
    else $error("pulse 1 sequence left early");
  a_breathe_stops: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_RUN && bus.mode == MODE_BREATHE && fall)
    |=> state_reg == ST_IDLE ##1 level_reg == LEVEL_MIN)
    else $error("breathe did not stop on release");
  a_direct_start: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_IDLE && bus.mode == MODE_DIRECT && rise)
    |=> state_reg == ST_RUN ##1 level_reg == LEVEL_MAX)
    else $error("direct did not actuate");
  a_p2_finish_cnt: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_RUN && bus.mode == MODE_PULSE2 && fall)
    |=> state_reg == ST_FINISH &&
    cnt_reg == {1'b0, $past(bus.p2_count)} + CNT_ONE + CNT_ONE)
    else $error("pulse 2 finish count wrong");
  a_period_zero: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_IDLE && rise && bus.mode == MODE_BREATHE &&
    bus.br_period == PERIOD_ZERO) |=> per_reg == PERIOD_ONE)
    else $error("zero period not treated as one");
  c_p1_done: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    state_reg == ST_RUN && bus.mode == MODE_PULSE1 ##1
    state_reg == ST_IDLE);
  c_cycle_end: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    cycle_end);
  c_p2_finish: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    state_reg == ST_FINISH ##1 state_reg == ST_IDLE);
endmodule

// *** logic/lbs_sequencer.sv ***
// Three-channel LED behavior sequencer: registers, triggers, PWM
// ==========================================================
`timescale 1ns/100ps
module lbs_sequencer
  import lbs_pkg::*;
#(
  parameter int FINE_CYC = FINE_TICK_CYC // Clocks per ramp step tick
) (
  input wire logic i_clk,                      // System clock
  input wire logic i_arst_n,                   // Async reset, low
  input wire logic [7:0] i_reg_addr,           // Register address
  input wire logic i_reg_wr,                   // Write strobe
  input wire logic [7:0] i_reg_wdata,          // Write data
  output logic [7:0] o_reg_rdata,              // Read data, 1 cycle
  input wire logic [LED_NUM-1:0] i_touch,      // Sensor touch level
  input wire logic [LED_NUM-1:0] i_link,       // Channel linked
  input wire logic [LED_NUM-1:0] i_host_drive_request, // Host drive
  input wire logic [LED_NUM-1:0] i_output_polarity, // 1 non-inverted
  input wire logic [COUNT_W-1:0] i_pulse_one_count, // Pulse 1 count
  input wire logic [COUNT_W-1:0] i_pulse_two_count, // Pulse 2 count
  input wire logic [PERIOD_W-1:0] i_p2_period, // Pulse 2 period
  input wire logic [PERIOD_W-1:0] i_br_period, // Breathe period
  input wire logic [7:0] i_duty_min,           // Minimum duty
  input wire logic [7:0] i_duty_max,           // Maximum duty
  input wire logic i_br_limits_set,            // Breathe uses inputs
  output logic [LED_NUM-1:0] o_led,            // LED pins
  output logic [LED_NUM-1:0] o_actuated        // Channel actuated
);
  localparam int FC_W = (FINE_CYC > 1) ? $clog2(FINE_CYC) : 1;
  localparam logic [FC_W-1:0] FINE_LAST = FC_W'(FINE_CYC - 1);

  // ==========================================================
  // Helpers
  // Map a ramp level onto the min..max duty window
  function automatic logic [7:0] lbs_scale(
    input logic [7:0] lvl,
    input logic [7:0] lo,
    input logic [7:0] hi);
    logic [15:0] prod;
    prod = 16'h0000;
    if (lvl == LEVEL_MAX) begin
      lbs_scale = hi;
    end else if (hi <= lo) begin
      lbs_scale = lo;
    end else begin
      prod = {8'h00, hi - lo} * {8'h00, lvl};
      lbs_scale = lo + prod[15:8];
    end
  endfunction

  logic [7:0] behavior_reg;
  logic [7:0] p1_period_reg;
  logic [7:0] rdata_reg;
  logic [FC_W-1:0] fine_cnt_reg;
  logic fine_tick_reg;
  logic [7:0] pwm_cnt_reg;
  logic [LED_NUM-1:0] led_reg;
  logic [LED_NUM-1:0] act_reg;
  logic [7:0] br_min;
  logic [7:0] br_max;

  lbs_chan_if ch_if [LED_NUM] ();

  // ==========================================================
  // Register file
  // Reserved bits 7:6 are dropped on write so they read as zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      behavior_reg <= BEHAVIOR_RST;
    end else if (i_reg_wr && i_reg_addr == ADDR_BEHAVIOR) begin
      behavior_reg <= i_reg_wdata & BEHAVIOR_MASK;
    end
  end

  // Period field plus start edge select in the top bit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p1_period_reg <= P1_PERIOD_RST;
    end else if (i_reg_wr && i_reg_addr == ADDR_P1_PERIOD) begin
      p1_period_reg <= i_reg_wdata;
    end
  end

  // Read data registered; unmapped addresses answer zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= RDATA_NONE;
    end else begin
      unique case (i_reg_addr)
        ADDR_BEHAVIOR: rdata_reg <= behavior_reg;
        ADDR_P1_PERIOD: rdata_reg <= p1_period_reg;
        default: rdata_reg <= RDATA_NONE;
      endcase
    end
  end

  // ==========================================================
  // Shared time base; every channel steps on the same tick
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fine_cnt_reg <= '0;
      fine_tick_reg <= 1'b0;
    end else if (fine_cnt_reg >= FINE_LAST) begin
      fine_cnt_reg <= '0;
      fine_tick_reg <= 1'b1;
    end else begin
      fine_cnt_reg <= fine_cnt_reg + 1'b1;
      fine_tick_reg <= 1'b0;
    end
  end

  // Free-running PWM counter at the highest rate the clock allows;
  // the duty window alone shapes brightness, rise and fall are zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwm_cnt_reg <= 8'h00;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // Breathe falls back to full-range limits unless told otherwise
  assign br_min = i_br_limits_set ? i_duty_min : DUTY_MIN_DEF;
  assign br_max = i_br_limits_set ? i_duty_max : DUTY_MAX_DEF;

  // ==========================================================
  // Channels
  for (genvar g = 0; g < LED_NUM; g++) begin : g_ch
    logic [7:0] duty;
    logic on;
    // Linked channels see only the sensor; the drive bit is dropped
    assign ch_if[g].trig = i_link[g] ? i_touch[g] :
      i_host_drive_request[g];
    assign ch_if[g].mode =
      lbs_mode_t'(behavior_reg[g*FIELD_W +: FIELD_W]);
    assign ch_if[g].start_on_release = p1_period_reg[P1_EDGE_BIT];
    assign ch_if[g].p1_period = p1_period_reg[PERIOD_W-1:0];
    assign ch_if[g].p2_period = i_p2_period;
    assign ch_if[g].br_period = i_br_period;
    assign ch_if[g].p1_count = i_pulse_one_count;
    assign ch_if[g].p2_count = i_pulse_two_count;
    assign ch_if[g].duty_min =
      (ch_if[g].mode == MODE_BREATHE) ? br_min : i_duty_min;
    assign ch_if[g].duty_max =
      (ch_if[g].mode == MODE_BREATHE) ? br_max : i_duty_max;
    assign ch_if[g].fine_tick = fine_tick_reg;

    lbs_chan lbs_chan_i (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .bus(ch_if[g])
    );

    assign duty = lbs_scale(ch_if[g].level, ch_if[g].run_min,
      ch_if[g].run_max);
    assign on = (duty == LEVEL_MAX) || (pwm_cnt_reg < duty);

    // Inverted polarity sinks current: asserted duty is a low pin
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        led_reg[g] <= 1'b1;
        act_reg[g] <= 1'b0;
      end else begin
        led_reg[g] <= i_output_polarity[g] ? on : ~on;
        act_reg[g] <= ch_if[g].actuated;
      end
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_led = led_reg;
  assign o_actuated = act_reg;

  // ==========================================================
  // Checks
  a_behavior_readback: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_reg_wr && i_reg_addr == ADDR_BEHAVIOR) ##1
    (!i_reg_wr && i_reg_addr == ADDR_BEHAVIOR)
    |=> o_reg_rdata == ($past(i_reg_wdata, 2) & BEHAVIOR_MASK))
    else $error("behavior byte readback wrong");
  a_edge_bit_store: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_reg_wr && i_reg_addr == ADDR_P1_PERIOD)
    |=> ch_if[0].start_on_release == $past(i_reg_wdata[P1_EDGE_BIT]))
    else $error("start edge select not taken");
  a_linked_ignore: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_link[1] && !i_touch[1] && ch_if[1].mode == MODE_DIRECT)[*3]
    |-> !o_actuated[1])
    else $error("linked LED followed host drive");
  a_idle_pin_level: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_arst_n && ch_if[0].level == LEVEL_MIN &&
    ch_if[0].run_min == DUTY_MIN_DEF)
    |=> o_led[0] == !$past(i_output_polarity[0]))
    else $error("idle pin level does not follow polarity");
  c_linked_touch: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    i_link[1] && $rose(o_actuated[1]));
  c_breathe_run: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    ch_if[1].mode == MODE_BREATHE && o_actuated[1]);
endmodule

// *** tb/lbs_led_model.sv ***
// Behavioural LED on one sequencer pin that counts duty-asserted cycles
`timescale 1ns/100ps
module lbs_led_model (
  input wire logic i_clk, // System clock
  input wire logic i_pin, // Pin driven by the sequencer
  input wire logic i_pol, // Polarity, 1 non-inverted
  input wire logic i_clr, // Restart the count
  output int o_lit        // Cycles with duty asserted
);
  // ==========================================================
  // Duty counter; push-pull pin, so no pull level is needed here
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_lit <= 0;
    end else if (i_pin === i_pol) begin
      o_lit <= o_lit + 1;
    end
  end
endmodule

// *** tb/led_behavior_sequencer_bench.sv ***
// Self-checking bench for the three-channel LED behavior sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module led_behavior_sequencer_bench;
  import lbs_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, clr = 1'b1;
  logic [2:0] touch = 3'h0, link = 3'h0, drv = 3'h0, pol = 3'h5;
  logic [2:0] c1 = 3'h0, c2 = 3'h0, led, act;
  logic [6:0] p2p = 7'h01, brp = 7'h00;
  logic [7:0] dmin = 8'h00, dmax = 8'hFF;
  logic lims = 1'b0;
  int mismatches = 0, n_compared = 0, lit0, lit1;
  // ==========================================================
  // Clock at 200 MHz; short ramp tick keeps a 32 ms unit at 1024 clocks
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  lbs_sequencer #(.FINE_CYC(2)) lbs_sequencer_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_touch(touch), .i_link(link), .i_host_drive_request(drv),
    .i_output_polarity(pol), .i_pulse_one_count(c1),
    .i_pulse_two_count(c2), .i_p2_period(p2p), .i_br_period(brp),
    .i_duty_min(dmin), .i_duty_max(dmax), .i_br_limits_set(lims),
    .o_led(led), .o_actuated(act));
  lbs_led_model lbs_led_model_i (.i_clk(i_clk), .i_pin(led[0]),
    .i_pol(pol[0]), .i_clr(clr), .o_lit(lit0));
  lbs_led_model lbs_led_model_i1 (.i_clk(i_clk), .i_pin(led[1]),
    .i_pol(pol[1]), .i_clr(clr), .o_lit(lit1));
  // ==========================================================
  // Register port tasks: one-cycle write strobe, read two edges later
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge i_clk) wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk) addr <= a;
    repeat (2) @(posedge i_clk);
    #1 `CHK(rdata, e)
  endtask
  task automatic set_drv(input int ch, input logic v);
    @(posedge i_clk) drv[ch] <= v;
  endtask
  // Bounded wait for a channel's actuated flag, cycle count in [lo, hi]
  task automatic wait_act(input int ch, input logic v, input int lo,
                          input int hi);
    int n;
    n = 0;
    #1;
    while (act[ch] !== v && n <= hi) begin
      @(posedge i_clk);
      #1 n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog: the tests need about 10600 clocks
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    results();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Register reset values, masking and unmapped reads
    rd_chk(8'h81, 8'h00);
    rd_chk(8'h84, 8'h20);
    rd_chk(8'h82, 8'h00);
    wr_reg(8'h81, 8'hFF);
    rd_chk(8'h81, 8'h3F);
    wr_reg(8'h84, 8'hA5);
    rd_chk(8'h84, 8'hA5);
    wr_reg(8'h81, 8'h00);
    $display("test registers done");
    // Direct on the host bit, duty seen by the LED models
    set_drv(0, 1'b1);
    wait_act(0, 1'b1, 1, 4);
    repeat (4) @(posedge i_clk);
    clr <= 1'b0;
    repeat (256) @(posedge i_clk);
    #1 `CHK(lit0 >= 250, 1'b1)
    `CHK(lit1, 0)
    set_drv(0, 1'b0);
    wait_act(0, 1'b0, 1, 4);
    // Linked channel ignores its host bit and follows touch
    @(posedge i_clk) link[1] <= 1'b1;
    set_drv(1, 1'b1);
    repeat (10) @(posedge i_clk);
    #1 `CHK(act[1], 1'b0)
    @(posedge i_clk) touch[1] <= 1'b1;
    wait_act(1, 1'b1, 1, 4);
    @(posedge i_clk) touch[1] <= 1'b0;
    wait_act(1, 1'b0, 1, 4);
    // Link switch with the new source inactive acts as a release
    set_drv(2, 1'b1);
    wait_act(2, 1'b1, 1, 4);
    @(posedge i_clk) link[2] <= 1'b1;
    wait_act(2, 1'b0, 1, 4);
    @(posedge i_clk) touch[2] <= 1'b1;
    wait_act(2, 1'b1, 1, 4);
    repeat (2) @(posedge i_clk);
    #1 `CHK(led[2], 1'b1)
    $display("test direct done");
    // Pulse 1: one pulse of 1024 clocks, a clear and set inside is lost
    wr_reg(8'h84, 8'h01);
    wr_reg(8'h81, 8'h01);
    set_drv(0, 1'b1);
    wait_act(0, 1'b1, 1, 4);
    set_drv(0, 1'b0);
    set_drv(0, 1'b1);
    wait_act(0, 1'b0, 990, 1040);
    repeat (50) @(posedge i_clk);
    #1 `CHK(act[0], 1'b0)
    // Count field 1 gives two pulses
    @(posedge i_clk) c1 <= 3'h1;
    set_drv(0, 1'b0);
    set_drv(0, 1'b1);
    wait_act(0, 1'b1, 1, 4);
    wait_act(0, 1'b0, 2010, 2070);
    // Start on release, with period zero acting as one
    @(posedge i_clk) c1 <= 3'h0;
    wr_reg(8'h84, 8'h80);
    set_drv(0, 1'b0);
    wait_act(0, 1'b1, 1, 4);
    wait_act(0, 1'b0, 990, 1040);
    $display("test pulse one done");
    // Breathe keeps going while the host bit is set; period zero as one
    wr_reg(8'h81, 8'h03);
    set_drv(0, 1'b1);
    wait_act(0, 1'b1, 1, 4);
    repeat (3000) @(posedge i_clk);
    #1 `CHK(act[0], 1'b1)
    set_drv(0, 1'b0);
    wait_act(0, 1'b0, 1, 4);
    $display("test breathe done");
    // Pulse 2 runs until release, ends the pulse in progress, then one more
    wr_reg(8'h81, 8'h02);
    set_drv(0, 1'b1);
    wait_act(0, 1'b1, 1, 4);
    repeat (2000) @(posedge i_clk);
    #1 `CHK(act[0], 1'b1)
    set_drv(0, 1'b0);
    wait_act(0, 1'b0, 1030, 1110);
    $display("test pulse two done");
    results();
  end
endmodule
